// *** hdl/async_uart_receiver_wake.sv ***
/*
  Asynchronous serial receiver with address detect and auto-wake-up,
  registers on an AHB-Lite slave. Assumes one clock clk_sys at 50 MHz,
  the bus hready looped from hreadyout, and sleepActive from the core.
*/
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
// Notes on behaviour
// R1 - line sampled at sixteen times bit rate; shifter advances once per bit
// R2 - async receive runs when sync-mode clear and port enable set
// R3 - nine-bit enable gives nine data bits; ninth readable in status register
// R4 - characters accepted only while continuous receive enable is set
// R5 - completion sets receive flag; interrupt request only when enabled
// R6 - low eight data bits delivered through the receive data register
// R7 - errors stay latched until continuous receive enable is cleared
// R8 - address detect in nine-bit mode drops non-address characters
// R9 - ninth bit one marks an address; it loads and sets the flag
// R10 - in sleep the generator stops and no character is received
// R11 - wake enable (baud control bit 1) holds receiver idle, watches line
// R12 - with wake enabled, a falling line edge sets the receive flag
// R13 - wake interrupt raised in normal operation and in sleep alike
// R14 - reading receive data register clears the pending receive flag
// R15 - first rising edge after wake event clears wake enable itself
// R16 - software discards the data read after a wake event
// R17 - sender's first character after wake is all zero bits
// R18 - sender leaves enough break and idle time for oscillator start
// R19 - software checks receiver idle before setting wake enable
// R20 - frame: one start, eight or nine data bits LSB first, one stop
// R21 - generator runs at x16 or x64 bit rate by speed selects
// R22 - sync-mode select is bit 4 of transmit status register
`timescale 1ns/10ps
`default_nettype none
module async_uart_receiver_wake (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [uart_rx_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [uart_rx_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [uart_rx_pkg::DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial line and system
  input wire logic rxPin,
  input wire logic sleepActive,
  output logic rxIrqReq
);
  import uart_rx_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  rx_tick_if tk();
  logic [7:0] rcsCtl_q;
  logic [7:0] txCtl_q;
  logic [7:0] baudCtl_q;
  logic [7:0] divHi_q;
  logic [7:0] divLo_q;
  logic irqEn_q;
  logic wue_q;
  logic wakeSeen_q;
  logic flag_q;
  logic framing_error_flag_q;
  logic overrun_error_flag_q;
  logic ninth_q;
  logic [7:0] rxData_q;
  logic pend_q;
  logic pendWr_q;
  logic [7:0] pendAddr_q;
  logic [DATA_W-1:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic rxIrqReq_q;
  rx_state_t state_q, state_d;
  logic [3:0] phase_q, phase_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [8:0] shift_q, shift_d;

  function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire accept = hsel & htrans[1] & hready;
  wire wrAct = pend_q & pendWr_q;
  wire rdAct = pend_q & ~pendWr_q;
  wire [7:0] wb = hwdata[7:0];
  wire wrRcs = wrAct & hits(pendAddr_q, OFF_RCV_STAT);
  wire wrTx = wrAct & hits(pendAddr_q, OFF_TX_STAT);
  wire wrBaud = wrAct & hits(pendAddr_q, OFF_BAUD_CTL);
  wire wrHi = wrAct & hits(pendAddr_q, OFF_DIV_HI);
  wire wrLo = wrAct & hits(pendAddr_q, OFF_DIV_LO);
  wire wrIrq = wrAct & hits(pendAddr_q, OFF_IRQ_CTL);
  wire rdData = rdAct & hits(pendAddr_q, OFF_RCV_DATA);

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire asyncOn = rcsCtl_q[RS_PORT_EN] & ~txCtl_q[TS_SYNC]; // R2 R22
  wire nineEn = rcsCtl_q[RS_NINE_EN];
  wire crenOn = rcsCtl_q[RS_CONT_EN];
  wire rxEn = asyncOn & crenOn & ~wue_q & ~sleepActive & ~overrun_error_flag_q; // R4 R10 R11
  wire brgRun = asyncOn & ~sleepActive; // R10
  wire [15:0] divisor = baudCtl_q[BC_WIDE] ? {divHi_q, divLo_q} : {8'h00, divLo_q};
  wire atMid = (phase_q == PHASE_MID);
  wire atLast = (phase_q == PHASE_LAST);
  wire [3:0] lastBit = nineEn ? BITS9_LAST : BITS8_LAST; // R3 R20
  wire charDone = rxEn & tk.tick16 & (state_q == ST_STOP) & atMid;
  wire [7:0] dataByte = nineEn ? shift_q[7:0] : shift_q[8:1]; // R6
  wire ninthBit = nineEn & shift_q[8];
  wire addrDrop = nineEn & rcsCtl_q[RS_ADDR_EN] & ~ninthBit; // R8 R9
  wire keepChar = charDone & ~addrDrop;
  wire loadChar = keepChar & ~flag_q;
  wire overrun = keepChar & flag_q;
  wire wakeEvent = asyncOn & wue_q & ~wakeSeen_q & tk.fallEdge; // R12
  wire wakeDone = wue_q & wakeSeen_q & tk.riseEdge; // R15
  wire errClr = wrRcs & ~wb[RS_CONT_EN]; // R7
  wire flagSet = loadChar | wakeEvent;
  // a wake event in the cycle of the read keeps the flag set
  wire flag_d = flagSet | (flag_q & ~rdData); // R5 R14
  wire receiver_idle_status = (state_q == ST_IDLE);
  wire [7:0] rcsRead = {rcsCtl_q[7:3], framing_error_flag_q, overrun_error_flag_q, ninth_q};
  wire [7:0] txRead = {txCtl_q[7:2], 1'b1, txCtl_q[0]};
  wire [7:0] baudRead = {1'b0, receiver_idle_status, baudCtl_q[5:3], 1'b0, wue_q, baudCtl_q[0]};
  wire [7:0] rdMux =
    hits(pendAddr_q, OFF_RCV_STAT) ? rcsRead :
    hits(pendAddr_q, OFF_RCV_DATA) ? rxData_q :
    hits(pendAddr_q, OFF_TX_STAT) ? txRead :
    hits(pendAddr_q, OFF_BAUD_CTL) ? baudRead :
    hits(pendAddr_q, OFF_DIV_HI) ? divHi_q :
    hits(pendAddr_q, OFF_DIV_LO) ? divLo_q :
    hits(pendAddr_q, OFF_IRQ_CTL) ? {6'h00, flag_q, irqEn_q} : 8'h00;

  // ----------------------------------------
  // sub-blocks
  // ----------------------------------------
  baud_tick_gen u_gen (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(brgRun),
    .divisor(divisor),
    .wideSel(baudCtl_q[BC_WIDE]),
    .highSel(txCtl_q[TS_HIGH_SPEED]),
    .tk(tk.gen)
  );

  rx_line_sampler u_smp (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .rxPin(rxPin),
    .tk(tk.smp)
  );

  // ----------------------------------------
  // AHB-Lite slave: one wait state per transfer
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 1'b0;
      pendWr_q <= 1'b0;
      pendAddr_q <= 8'h00;
      hreadyout_q <= 1'b1;
      hrdata_q <= '0;
    end else begin
      pend_q <= accept;
      hreadyout_q <= ~accept;
      if (accept) begin
        pendWr_q <= hwrite;
        pendAddr_q <= haddr[7:0];
      end
      if (rdAct) begin
        hrdata_q <= {24'h000000, rdMux};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rcsCtl_q <= RCV_STAT_RST;
      txCtl_q <= TX_STAT_RST;
      baudCtl_q <= BAUD_CTL_RST;
      divHi_q <= DIV_RST;
      divLo_q <= DIV_RST;
      irqEn_q <= 1'b0;
    end else begin
      if (wrRcs) rcsCtl_q <= wb & RCV_STAT_WMASK;
      if (wrTx) txCtl_q <= wb & TX_STAT_WMASK;
      if (wrBaud) baudCtl_q <= wb & BAUD_CTL_WMASK;
      if (wrHi) divHi_q <= wb;
      if (wrLo) divLo_q <= wb;
      if (wrIrq) irqEn_q <= wb[IC_ENABLE];
    end
  end

  // ----------------------------------------
  // wake-up control
  // ----------------------------------------
  // a software write to baud control in the same cycle takes priority
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wue_q <= 1'b0;
      wakeSeen_q <= 1'b0;
    end else begin
      if (wrBaud) wue_q <= wb[BC_WAKE]; // R11
      else if (wakeDone) wue_q <= 1'b0; // R15
      if (!wue_q || wakeDone) wakeSeen_q <= 1'b0;
      else if (wakeEvent) wakeSeen_q <= 1'b1; // R12
    end
  end

  // ----------------------------------------
  // frame state machine
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    if (!rxEn) begin
      state_d = ST_IDLE;
      phase_d = 4'h0;
    end else if (tk.tick16) begin
      phase_d = phase_q + 4'h1; // R1
      unique case (state_q)
        ST_IDLE: begin
          phase_d = 4'h0;
          if (!tk.rxLevel) state_d = ST_START;
        end
        ST_START: begin
          if (atMid && tk.rxVote) state_d = ST_IDLE;
          else if (atLast) state_d = ST_DATA;
          bitCnt_d = 4'h0;
        end
        ST_DATA: begin
          if (atMid) shift_d = {tk.rxVote, shift_q[8:1]}; // R20
          if (atLast) begin
            bitCnt_d = bitCnt_q + 4'h1;
            if (bitCnt_q == lastBit) state_d = ST_STOP; // R3
          end
        end
        ST_STOP: begin
          if (atMid) state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      phase_q <= 4'h0;
      bitCnt_q <= 4'h0;
      shift_q <= 9'h000;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
    end
  end

  // ----------------------------------------
  // receive buffer, flag and errors
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rxData_q <= 8'h00;
      ninth_q <= 1'b0;
      flag_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      overrun_error_flag_q <= 1'b0;
      rxIrqReq_q <= 1'b0;
    end else begin
      if (loadChar) begin
        rxData_q <= dataByte; // R6 R9
        ninth_q <= ninthBit; // R3
      end
      flag_q <= flag_d;
      framing_error_flag_q <= (loadChar & ~tk.rxVote) | (framing_error_flag_q & ~errClr); // R7
      overrun_error_flag_q <= overrun | (overrun_error_flag_q & ~errClr); // R7
      rxIrqReq_q <= flag_d & irqEn_q; // R5 R13
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign rxIrqReq = rxIrqReq_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_wake_sets_flag: assert property (wakeEvent |=> flag_q [*2] or (flag_q ##1 !flag_q))
    else $error("wake event did not set receive flag"); // R12
  a_wake_self_clear: assert property (wakeDone && !wrBaud |=> !wue_q && !wakeSeen_q)
    else $error("wake enable not cleared on rising edge"); // R15
  a_wake_holds_idle: assert property (wue_q |=> state_q == ST_IDLE)
    else $error("receiver left idle while wake enabled"); // R11
  a_irq_gated: assert property (!irqEn_q [*2] |-> !rxIrqReq_q)
    else $error("interrupt request without enable"); // R5
  a_read_clears: assert property (rdData && !flagSet |=> !flag_q)
    else $error("data read did not clear receive flag"); // R14
  a_sleep_no_rx: assert property (sleepActive [*2] |-> state_q == ST_IDLE)
    else $error("reception active during sleep"); // R10
  a_addr_filter: assert property (charDone && addrDrop |=> $stable(rxData_q) && $stable(flag_q))
    else $error("non-address character passed"); // R8
  a_char_loads: assert property (loadChar |=> flag_q && rxData_q == $past(dataByte))
    else $error("character not delivered to data register"); // R6
  a_err_sticky: assert property (overrun_error_flag_q && !errClr |=> overrun_error_flag_q)
    else $error("overrun error lost while enabled"); // R7
  a_err_cleared: assert property (!crenOn [*2] |-> !framing_error_flag_q && !overrun_error_flag_q)
    else $error("errors remain with receive disabled"); // R7
  a_bus_wait: assert property (accept |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait state");
endmodule // async_uart_receiver_wake
`default_nettype wire

// *** hdl/baud_tick_gen.sv ***
/*
  Baud rate generator: divisor counter plus x64 prescale, one-cycle enable
  at sixteen times the bit rate. Assumes divisor and mode bits are static
  while run is high.
*/
`timescale 1ns/10ps
`default_nettype none
module baud_tick_gen
  import uart_rx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // configuration
  input wire logic run,
  input wire logic [15:0] divisor,
  input wire logic wideSel,
  input wire logic highSel,
  // ticks out
  rx_tick_if.gen tk
);
  logic [15:0] cnt_q;
  logic [1:0] pre_q;
  logic tick_q;
  wire reload = (cnt_q == 16'h0000);
  // slow mode runs the generator at x64 and divides by four for sampling
  wire x64Mode = ~wideSel & ~highSel;
  wire preWrap = ~x64Mode | (pre_q == X64_PRESCALE);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 16'h0000;
      pre_q <= 2'h0;
      tick_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= divisor;
      pre_q <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= reload & preWrap; // R21
      if (reload) begin
        cnt_q <= divisor;
        pre_q <= preWrap ? 2'h0 : pre_q + 2'h1;
      end else begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  assign tk.tick16 = tick_q;
endmodule // baud_tick_gen
`default_nettype wire

// *** hdl/rx_line_sampler.sv ***
/*
  Receive line synchroniser, edge detector and three-sample majority vote
  taken on each x16 tick. Assumes rxPin is asynchronous to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module rx_line_sampler (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // serial line
  input wire logic rxPin,
  // sampled view
  rx_tick_if.smp tk
);
  logic sync1_q;
  logic sync2_q;
  logic dly_q;
  logic [2:0] win_q;

  function automatic logic majority(input logic [2:0] s);
    return (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  // idle line is high, so reset to high to avoid a false start
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      dly_q <= 1'b1;
      win_q <= 3'h7;
    end else begin
      sync1_q <= rxPin;
      sync2_q <= sync1_q;
      dly_q <= sync2_q;
      if (tk.tick16) begin
        win_q <= {win_q[1:0], sync2_q}; // R1
      end
    end
  end

  assign tk.rxLevel = sync2_q;
  assign tk.rxVote = majority(win_q);
  assign tk.fallEdge = dly_q & ~sync2_q;
  assign tk.riseEdge = ~dly_q & sync2_q;
endmodule // rx_line_sampler
`default_nettype wire

// *** hdl/rx_tick_if.sv ***
/*
  Carrier between baud generator, line sampler and receiver core.
  Assumes all three run on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
interface rx_tick_if;
  logic tick16;
  logic rxLevel;
  logic rxVote;
  logic fallEdge;
  logic riseEdge;
  modport gen(output tick16);
  modport smp(input tick16, output rxLevel, rxVote, fallEdge, riseEdge);
  modport core(input tick16, rxLevel, rxVote, fallEdge, riseEdge);
endinterface
`default_nettype wire

// *** hdl/uart_rx_pkg.sv ***
/*
  Shared constants of the asynchronous receiver: register offsets, bit
  positions, reset values, write masks, sampling counts and the frame states.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package uart_rx_pkg;
  // ----------------------------------------
  // bus and register layout
  // ----------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam logic [7:0] OFF_RCV_STAT = 8'h00;
  localparam logic [7:0] OFF_RCV_DATA = 8'h04;
  localparam logic [7:0] OFF_TX_STAT = 8'h08;
  localparam logic [7:0] OFF_BAUD_CTL = 8'h0c;
  localparam logic [7:0] OFF_DIV_HI = 8'h10;
  localparam logic [7:0] OFF_DIV_LO = 8'h14;
  localparam logic [7:0] OFF_IRQ_CTL = 8'h18;
  // receive_status_control bits
  localparam int RS_PORT_EN = 7;
  localparam int RS_NINE_EN = 6;
  localparam int RS_CONT_EN = 4;
  localparam int RS_ADDR_EN = 3;
  // transmit_status_control bits
  localparam int TS_SYNC = 4;
  localparam int TS_HIGH_SPEED = 2;
  // baud_control bits
  localparam int BC_WIDE = 3;
  localparam int BC_WAKE = 1;
  // receive interrupt control bits
  localparam int IC_ENABLE = 0;
  // reset values and write masks
  localparam logic [7:0] RCV_STAT_RST = 8'h00;
  localparam logic [7:0] RCV_STAT_WMASK = 8'hf8;
  localparam logic [7:0] TX_STAT_RST = 8'h00;
  localparam logic [7:0] TX_STAT_WMASK = 8'hfd;
  localparam logic [7:0] BAUD_CTL_RST = 8'h00;
  localparam logic [7:0] BAUD_CTL_WMASK = 8'h39;
  localparam logic [7:0] DIV_RST = 8'h00;
  // ----------------------------------------
  // sampling counts
  // ----------------------------------------
  localparam logic [3:0] PHASE_MID = 4'h8;
  localparam logic [3:0] PHASE_LAST = 4'hf;
  localparam logic [1:0] X64_PRESCALE = 2'h3;
  localparam logic [3:0] BITS8_LAST = 4'h7;
  localparam logic [3:0] BITS9_LAST = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b10,
    ST_STOP = 2'b11
  } rx_state_t;
endpackage

// *** tb/serial_sender.sv ***
/*
  Behavioural remote asynchronous transmitter driving the receive line.
  Assumes the bench calls its task from one process at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_sender (
  // clock
  input wire logic clk_sys,
  // serial line
  output logic line
);
  // the line idles high, as the pull-up leaves it
  initial line = 1'b1;
  // ----------------------------------------
  // one frame: start, data lsb first, stop
  // ----------------------------------------
  task automatic send(input logic [8:0] d, input int nb, input int bc, input logic stopLvl);
    line <= 1'b0;
    repeat (bc) @(posedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      line <= d[i];
      repeat (bc) @(posedge clk_sys);
    end
    line <= stopLvl;
    repeat (bc) @(posedge clk_sys);
    // one idle bit so the receiver is settled before the next start
    line <= 1'b1;
    repeat (bc) @(posedge clk_sys);
  endtask
endmodule // serial_sender
`default_nettype wire

// *** tb/test_async_uart_receiver_wake.sv ***
/*
  Self-checking bench: AHB-Lite master tasks, random characters from the
  remote sender, error, address and wake cases.
  Assumes hready is looped from hreadyout and one 50 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("mismatch %0t got %h exp %h", $time, g, e); end end
module test_async_uart_receiver_wake;
  import uart_rx_pkg::*;
  logic clk_sys, nrst, hsel, hwrite, hready, hreadyout, hresp, sleepActive, line, rxIrqReq;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [DATA_W-1:0] hwdata, hrdata, rd;
  logic [7:0] dv;
  logic [8:0] d9, d9b;
  int mismatches, cmp_count, cycles, seed, bc;

  assign hready = hreadyout;
  async_uart_receiver_wake dut (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rxPin(line), .sleepActive(sleepActive), .rxIrqReq(rxIrqReq));
  serial_sender far (.clk_sys(clk_sys), .line(line));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // slowest run is near 25k cycles, so this only cuts a hang
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      $display("mismatch %0t timeout", $time);
      stop_test();
    end
  end
  // ----------------------------------------
  // bus master and expectations
  // ----------------------------------------
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, rd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 8'h00, rd);
    `CHK(rd, e)
  endtask
  task automatic tx(input logic [8:0] d, input int nb);
    far.send(d, nb, bc, 1'b1);
  endtask
  function automatic logic [31:0] statExp(input logic [7:0] c, input logic fe, input logic oe, input logic n9);
    return {24'h000000, (c & RCV_STAT_WMASK) | {5'h00, fe, oe, n9}};
  endfunction
  task stop_test;
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 69;
    {nrst, hsel, hwrite, sleepActive} = 4'h0;
    haddr = '0;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = '0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rdc(OFF_RCV_STAT, 32'h00);
    rdc(OFF_TX_STAT, 32'h02);
    rdc(OFF_BAUD_CTL, 32'h40);
    wr(OFF_TX_STAT, 8'hff);
    rdc(OFF_TX_STAT, 32'hff);
    wr(OFF_BAUD_CTL, 8'hff);
    // writing all ones also sets wake enable, which reads back in bit 1
    rdc(OFF_BAUD_CTL, 32'h7b);
    wr(8'h1c, 8'hff);
    rdc(8'h1c, 32'h00);
    wr(OFF_DIV_HI, 8'ha5);
    rdc(OFF_DIV_HI, 32'ha5);
    `CHK(hresp, 1'b0)
    dv = 8'($random(seed)) & 8'h03;
    bc = (int'(dv) + 1) * 16;
    wr(OFF_DIV_HI, 8'h00);
    wr(OFF_DIV_LO, dv);
    wr(OFF_TX_STAT, 8'h04);
    wr(OFF_BAUD_CTL, 8'h08);
    wr(OFF_IRQ_CTL, 8'h01);
    wr(OFF_RCV_STAT, 8'h90);
    // random characters with the all-zero and all-one corners first
    for (int i = 0; i < 6; i++) begin
      d9 = (i == 0) ? 9'h000 : (i == 1) ? 9'h0ff : 9'($random(seed));
      tx(d9, 8);
      rdc(OFF_IRQ_CTL, 32'h03);
      `CHK(rxIrqReq, 1'b1)
      rdc(OFF_RCV_DATA, {24'h000000, d9[7:0]});
      rdc(OFF_IRQ_CTL, 32'h01);
    end
    wr(OFF_IRQ_CTL, 8'h00);
    d9 = 9'($random(seed));
    tx(d9, 8);
    `CHK(rxIrqReq, 1'b0)
    rdc(OFF_IRQ_CTL, 32'h02);
    rdc(OFF_RCV_DATA, {24'h000000, d9[7:0]});
    wr(OFF_RCV_STAT, 8'hd0);
    for (int i = 1; i >= 0; i--) begin
      d9 = {i[0], 8'($random(seed))};
      tx(d9, 9);
      rdc(OFF_RCV_STAT, statExp(8'hd0, 1'b0, 1'b0, d9[8]));
      rdc(OFF_RCV_DATA, {24'h000000, d9[7:0]});
    end
    // address detect: data dropped, address kept, then all pass
    wr(OFF_RCV_STAT, 8'hd8);
    tx({1'b0, 8'($random(seed))}, 9);
    rdc(OFF_IRQ_CTL, 32'h00);
    d9 = {1'b1, 8'($random(seed))};
    tx(d9, 9);
    rdc(OFF_IRQ_CTL, 32'h02);
    rdc(OFF_RCV_DATA, {24'h000000, d9[7:0]});
    wr(OFF_RCV_STAT, 8'hd0);
    d9 = {1'b0, 8'($random(seed))};
    tx(d9, 9);
    rdc(OFF_RCV_DATA, {24'h000000, d9[7:0]});
    // framing error stays until continuous enable is cleared
    wr(OFF_RCV_STAT, 8'h90);
    far.send(9'h05a, 8, bc, 1'b0);
    rdc(OFF_RCV_STAT, statExp(8'h90, 1'b1, 1'b0, 1'b0));
    rdc(OFF_RCV_DATA, 32'h5a);
    tx(9'h033, 8);
    rdc(OFF_RCV_STAT, statExp(8'h90, 1'b1, 1'b0, 1'b0));
    rdc(OFF_RCV_DATA, 32'h33);
    wr(OFF_RCV_STAT, 8'h80);
    rdc(OFF_RCV_STAT, statExp(8'h80, 1'b0, 1'b0, 1'b0));
    // overrun: second character dropped, reception stalls
    wr(OFF_RCV_STAT, 8'h90);
    d9 = 9'($random(seed));
    d9b = 9'($random(seed));
    tx(d9, 8);
    tx(d9b, 8);
    rdc(OFF_RCV_STAT, statExp(8'h90, 1'b0, 1'b1, 1'b0));
    rdc(OFF_RCV_DATA, {24'h000000, d9[7:0]});
    tx(d9b, 8);
    rdc(OFF_IRQ_CTL, 32'h00);
    wr(OFF_RCV_STAT, 8'h80);
    rdc(OFF_RCV_STAT, statExp(8'h80, 1'b0, 1'b0, 1'b0));
    tx(9'h0c3, 8);
    rdc(OFF_IRQ_CTL, 32'h00);
    wr(OFF_RCV_STAT, 8'h90);
    sleepActive <= 1'b1;
    tx(9'h0c3, 8);
    rdc(OFF_IRQ_CTL, 32'h00);
    sleepActive <= 1'b0;
    // slow generator: both selects low
    wr(OFF_TX_STAT, 8'h00);
    wr(OFF_BAUD_CTL, 8'h00);
    bc = (int'(dv) + 1) * 64;
    d9 = 9'($random(seed));
    tx(d9, 8);
    rdc(OFF_RCV_DATA, {24'h000000, d9[7:0]});
    // wake-up, awake and asleep
    wr(OFF_IRQ_CTL, 8'h01);
    for (int s = 0; s < 2; s++) begin
      sleepActive <= s[0];
      rdc(OFF_BAUD_CTL, 32'h40);
      wr(OFF_BAUD_CTL, 8'h02);
      rdc(OFF_BAUD_CTL, 32'h42);
      fork
        tx(9'h000, 8);
        begin
          repeat (bc * 3) @(posedge clk_sys);
          rdc(OFF_IRQ_CTL, 32'h03);
          `CHK(rxIrqReq, 1'b1)
          rdc(OFF_BAUD_CTL, 32'h42);
        end
      join
      rdc(OFF_BAUD_CTL, 32'h40);
      bus(OFF_RCV_DATA, 1'b0, 8'h00, rd);
      rdc(OFF_IRQ_CTL, 32'h01);
    end
    sleepActive <= 1'b0;
    d9 = 9'($random(seed));
    tx(d9, 8);
    rdc(OFF_RCV_DATA, {24'h000000, d9[7:0]});
    stop_test();
  end
endmodule // test_async_uart_receiver_wake
`default_nettype wire
